/* File: include/cpu_if_regs.svh */
// Register offsets, field positions and reset values for the CPU interface bank
`ifndef CPU_IF_REGS_SVH
`define CPU_IF_REGS_SVH

`define OFS_CTRL 12'h000
`define OFS_PMASK 12'h004
`define OFS_BPT 12'h008
`define OFS_ACK 12'h00C
`define OFS_EOI 12'h010
`define OFS_RUNPRI 12'h014
`define OFS_HIPEND 12'h018
`define OFS_ABPT 12'h01C
`define OFS_IDENT 12'h0FC
`define OFS_PID8 12'hFC0
`define OFS_PID4 12'hFD0
`define OFS_PID0 12'hFE0
`define OFS_CID0 12'hFF0

`define RST_CTRL 32'h0000_0000
`define RST_PMASK 32'h0000_0000
`define RST_ABPT 32'h0000_0000
`define RST_NO_IRQ 10'h3FF
`define RST_IDLE_PRI 8'hFF

`define CTRL_EN_S 0
`define CTRL_EN_NS 1
`define CTRL_FIQ_SEL 3

`define ID_PART_LSB 20
`define ID_ARCH_LSB 16
`define ID_REV_LSB 12
`define ID_CONT_LSB 8
`define PID8_IFBIT 7

`endif

/* File: include/cpu_if_pkg.sv */
// Types shared by the CPU interface register bank
package cpu_if_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_NS_BLOCKED = 3'b100
  } sig_state_t;
  typedef logic [31:0] word_t;
  typedef logic [9:0] int_id_t;
  typedef logic [7:0] prio_t;
endpackage

/* File: rtl/cpu_if_ident_rom.sv */
// Registered lookup of the identification words
`timescale 1ns/100ps
`include "cpu_if_regs.svh"
module cpu_if_ident_rom #(
  parameter logic [11:0] PART_NUM = 12'h123,      // Arbitrary value
  parameter logic [3:0] ARCH_NUM = 4'h2,          // Arbitrary value
  parameter logic [3:0] REV_NUM = 4'h3,           // Arbitrary value
  parameter logic [3:0] CONT_COUNT = 4'h5,        // Arbitrary value
  parameter logic [6:0] MAKER_CODE = 7'h2A,       // Arbitrary value
  parameter logic [63:0] PERIPH_ID = 64'h0000_0000_0000_0000,
  parameter logic [6:0] PID8_LOW = 7'h00
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [11:0] addr_i,
  output logic [31:0] data_o
);
  import cpu_if_pkg::*;
  word_t data_d;
  logic [1:0] idx;
  logic [31:0] cid;
  assign idx = addr_i[3:2];
  assign cid = 32'hC0DE_5EED; // Arbitrary value
  always_comb begin
    data_d = 32'h0000_0000;
    if (addr_i == `OFS_IDENT) begin
      data_d = {PART_NUM, ARCH_NUM, REV_NUM, CONT_COUNT, 1'b0, MAKER_CODE};
    end else if (addr_i == `OFS_PID8) begin
      data_d = {24'h00_0000, 1'b1, PID8_LOW};
    end else if (addr_i[11:4] == 8'(`OFS_PID4 >> 4)) begin
      data_d = {24'h00_0000, PERIPH_ID[{1'b1, idx, 3'b000} +: 8]};
    end else if (addr_i[11:4] == 8'(`OFS_PID0 >> 4)) begin
      data_d = {24'h00_0000, PERIPH_ID[{1'b0, idx, 3'b000} +: 8]};
    end else if (addr_i[11:4] == 8'(`OFS_CID0 >> 4)) begin
      data_d = {24'h00_0000, cid[{idx, 3'b000} +: 8]};
    end
  end
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_o <= 32'h0000_0000;
    end else begin
      data_o <= data_d;
    end
  end
endmodule

/* File: rtl/cpu_if_regbank.sv */
// CPU interface register bank with signalling and preemption logic
`timescale 1ns/100ps
`include "cpu_if_regs.svh"
module cpu_if_regbank #(
  parameter logic [2:0] BPT_RESET = 3'h2
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic sel_i,
  input wire logic write_i,
  input wire logic [11:0] addr_i,
  input wire logic [1:0] size_i,
  input wire logic [31:0] wdata_i,
  input wire logic secure_i,
  input wire logic [7:0] match_i,
  input wire logic [7:0] enable_i,
  input wire logic [7:0] cpu_id_i,
  input wire logic pend_valid_i,
  input wire cpu_if_pkg::int_id_t pend_id_i,
  input wire cpu_if_pkg::prio_t pend_prio_i,
  input wire logic pend_secure_i,
  input wire logic legacy_irq_n_i,
  input wire logic legacy_fiq_n_i,
  output cpu_if_pkg::word_t rdata_o,
  output logic ready_o,
  output logic irq_n_o,
  output logic fiq_n_o,
  output logic [9:0] eoi_id_o,
  output logic eoi_valid_o
);
  import cpu_if_pkg::*;

  word_t ctrl_q, ctrl_d, pmask_q, pmask_d;
  logic [2:0] bpt_q, bpt_d, abpt_q, abpt_d;
  int_id_t ack_q, ack_d;
  prio_t run_q, run_d;
  sig_state_t st_q, st_d;
  logic [1:0] rd_q, rd_d;
  word_t local_q, local_d;
  logic irq_d, fiq_d;
  logic [9:0] eoi_id_d;
  logic eoi_valid_d;
  logic [1:0] lirq_s, lfiq_s;
  word_t rom_data;
  logic hit, acc_ok, wr, rd;
  word_t wmask;

  // Byte lanes follow little-endian addressing
  function automatic word_t lane_mask(input logic [1:0] sz, input logic [1:0] a);
    word_t m;
    m = 32'h0000_0000;
    case (sz)
      2'd0: m = 32'h0000_00FF << {a, 3'b000};
      2'd1: m = 32'h0000_FFFF << {a[1], 4'b0000};
      default: m = 32'hFFFF_FFFF;
    endcase
    return m;
  endfunction

  function automatic word_t merge(input word_t old, input word_t nw, input word_t m);
    return (old & ~m) | (nw & m);
  endfunction

  cpu_if_ident_rom u_rom (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .addr_i(addr_i),
    .data_o(rom_data)
  );

  // Interface answers only when its tie-offs match the requesting processor
  assign hit = sel_i && ((cpu_id_i & enable_i) == (match_i & enable_i));
  assign acc_ok = !(addr_i[11:2] == 10'(`OFS_ABPT >> 2)) || secure_i;
  assign wr = hit && write_i && acc_ok;
  assign rd = hit && !write_i;
  assign wmask = lane_mask(size_i, addr_i[1:0]);

  // Legacy inputs are pins, synchronised before use
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lirq_s <= 2'b11;
      lfiq_s <= 2'b11;
    end else begin
      lirq_s <= {lirq_s[0], legacy_irq_n_i};
      lfiq_s <= {lfiq_s[0], legacy_fiq_n_i};
    end
  end

  always_comb begin
    ctrl_d = ctrl_q;
    pmask_d = pmask_q;
    bpt_d = bpt_q;
    abpt_d = abpt_q;
    ack_d = ack_q;
    run_d = run_q;
    eoi_id_d = eoi_id_o;
    eoi_valid_d = 1'b0;
    if (wr) begin
      // Read-only offsets fall through unchanged
      case (addr_i[11:2])
        10'(`OFS_CTRL >> 2): ctrl_d = merge(ctrl_q, wdata_i, wmask) & 32'h0000_000F;
        10'(`OFS_PMASK >> 2): pmask_d = merge(pmask_q, wdata_i, wmask) & 32'h0000_00FF;
        10'(`OFS_BPT >> 2): if (wmask[0]) bpt_d = wdata_i[2:0];
        10'(`OFS_ABPT >> 2): if (wmask[0]) abpt_d = wdata_i[2:0];
        10'(`OFS_EOI >> 2): begin
          eoi_id_d = wdata_i[9:0];
          eoi_valid_d = 1'b1;
          run_d = `RST_IDLE_PRI;
          ack_d = `RST_NO_IRQ;
        end
        default: ;
      endcase
    end else if (rd && addr_i[11:2] == 10'(`OFS_ACK >> 2) && pend_valid_i
                 && pend_prio_i < pmask_q[7:0] && pend_prio_i < run_q
                 && (pend_secure_i ? ctrl_q[`CTRL_EN_S] : ctrl_q[`CTRL_EN_NS])) begin
      // A read of the acknowledge register takes the pending interrupt
      ack_d = pend_id_i;
      run_d = pend_prio_i;
    end
  end

  // Signalling state
  always_comb begin
    logic ns_ok, s_ok, beats;
    ns_ok = ctrl_q[`CTRL_EN_NS];
    s_ok = ctrl_q[`CTRL_EN_S];
    beats = pend_valid_i && pend_prio_i < pmask_q[7:0] && pend_prio_i < run_q;
    st_d = ST_IDLE;
    irq_d = 1'b1;
    fiq_d = 1'b1;
    case (st_q)
      ST_IDLE, ST_ACTIVE, ST_NS_BLOCKED: begin
        if (beats && !pend_secure_i && !ns_ok) begin
          // Blocked non-secure still outranks running secure work
          st_d = ST_NS_BLOCKED;
        end else if (beats && (pend_secure_i ? s_ok : ns_ok)) begin
          st_d = ST_ACTIVE;
          if (pend_secure_i && ctrl_q[`CTRL_FIQ_SEL]) fiq_d = 1'b0;
          else irq_d = 1'b0;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // Legacy pins bypass when the matching enable is clear; legacy IRQ not while secure is enabled with FIQ select
    if (!s_ok && !lfiq_s[1]) fiq_d = 1'b0;
    if (!ns_ok && !(s_ok && ctrl_q[`CTRL_FIQ_SEL]) && !lirq_s[1]) irq_d = 1'b0;
  end

  always_comb begin
    local_d = 32'h0000_0000;
    case (addr_i[11:2])
      10'(`OFS_CTRL >> 2): local_d = ctrl_q;
      10'(`OFS_PMASK >> 2): local_d = pmask_q;
      10'(`OFS_BPT >> 2): local_d = {29'h0, bpt_q};
      10'(`OFS_ACK >> 2): local_d = {22'h0, ack_d};
      10'(`OFS_RUNPRI >> 2): local_d = {24'h0, run_q};
      10'(`OFS_HIPEND >> 2): local_d = pend_valid_i ? {22'h0, pend_id_i} : {22'h0, `RST_NO_IRQ};
      10'(`OFS_ABPT >> 2): local_d = secure_i ? {29'h0, abpt_q} : 32'h0000_0000;
      default: local_d = 32'h0000_0000;
    endcase
    rd_d = {rd, addr_i[11:8] == 4'h0 && addr_i != `OFS_IDENT};
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= `RST_CTRL;
      pmask_q <= `RST_PMASK;
      bpt_q <= BPT_RESET;
      abpt_q <= 3'h0;
      ack_q <= `RST_NO_IRQ;
      run_q <= `RST_IDLE_PRI;
      st_q <= ST_IDLE;
      rd_q <= 2'b00;
      local_q <= 32'h0000_0000;
      irq_n_o <= 1'b1;
      fiq_n_o <= 1'b1;
      eoi_id_o <= 10'h000;
      eoi_valid_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      ready_o <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      pmask_q <= pmask_d;
      bpt_q <= bpt_d;
      abpt_q <= abpt_d;
      ack_q <= ack_d;
      run_q <= run_d;
      st_q <= st_d;
      rd_q <= rd_d;
      local_q <= local_d;
      irq_n_o <= irq_d;
      fiq_n_o <= fiq_d;
      eoi_id_o <= eoi_id_d;
      eoi_valid_o <= eoi_valid_d;
      rdata_o <= rd_q[1] ? (rd_q[0] ? local_q : rom_data) : 32'h0000_0000;
      ready_o <= hit;
    end
  end

  a_ctrl_reset: assert property (@(posedge sys_clk_i) $rose(resetn_i) |-> ctrl_q == `RST_CTRL)
    else $error("control not zero after reset");
  a_pmask_reset: assert property (@(posedge sys_clk_i) $rose(resetn_i) |-> pmask_q == `RST_PMASK)
    else $error("priority mask not zero after reset");
  a_run_idle: assert property (@(posedge sys_clk_i) $rose(resetn_i) |-> run_q == `RST_IDLE_PRI)
    else $error("running priority not idle after reset");
  a_ack_reset: assert property (@(posedge sys_clk_i) $rose(resetn_i) |-> ack_q == `RST_NO_IRQ)
    else $error("acknowledge not idle after reset");
  a_bpt_reset: assert property (@(posedge sys_clk_i) $rose(resetn_i)
    |-> bpt_q == BPT_RESET && abpt_q == 3'h0)
    else $error("binary points wrong after reset");

  a_ack_ro: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr && addr_i == `OFS_ACK |=> $stable(ack_q))
    else $error("acknowledge register changed by write");
  a_runpri_ro: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr && addr_i == `OFS_RUNPRI |=> $stable(run_q))
    else $error("running priority changed by write");
  a_pmask_lane: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr && addr_i == 12'h005 && size_i == 2'h0 |=> $stable(pmask_q))
    else $error("byte outside the mask field changed the mask");
  a_ctrl_lane: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr && addr_i == 12'h002 && size_i == 2'h1 |=> $stable(ctrl_q))
    else $error("upper halfword changed the control bits");
  a_bpt_lane: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr && addr_i == 12'h009 && size_i == 2'h0 |=> $stable(bpt_q))
    else $error("byte outside lane zero changed the binary point");
  a_abpt_secure: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    sel_i && write_i && !secure_i && addr_i == `OFS_ABPT |=> $stable(abpt_q))
    else $error("non-secure write reached aliased binary point");

  // Only an interface whose tie-offs match may answer
  a_ready_hit: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    hit |=> ready_o)
    else $error("selected interface did not answer");
  a_ready_miss: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    sel_i && !hit |=> !ready_o)
    else $error("unselected interface answered");

  // Read data leave two edges after the request, so the request must stand on two edges
  sequence s_rsvd_read;
    (rd && addr_i[11:5] == 7'h01) ##1 rd;
  endsequence
  sequence s_ns_abpt_read;
    (rd && !secure_i && addr_i == `OFS_ABPT) ##1 rd;
  endsequence
  sequence s_idle_pend_read;
    (rd && !pend_valid_i && addr_i == `OFS_HIPEND) ##1 rd;
  endsequence
  a_rsvd_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_rsvd_read |=> rdata_o == 32'h0000_0000)
    else $error("reserved offset did not read zero");
  a_abpt_hidden: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_ns_abpt_read |=> rdata_o == 32'h0000_0000)
    else $error("non-secure read saw aliased binary point");
  a_hipend_idle: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    s_idle_pend_read |=> rdata_o == {22'h0, `RST_NO_IRQ})
    else $error("highest pending not idle without a pending source");
  a_ack_take: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    rd && addr_i == `OFS_ACK && pend_valid_i && pend_prio_i < pmask_q[7:0] && pend_prio_i < run_q
    && (pend_secure_i ? ctrl_q[`CTRL_EN_S] : ctrl_q[`CTRL_EN_NS])
    |=> ack_q == $past(pend_id_i) && run_q == $past(pend_prio_i))
    else $error("acknowledge read did not take the pending interrupt");
  a_eoi_pulse: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr && addr_i == `OFS_EOI |=> eoi_valid_o ##1 !eoi_valid_o)
    else $error("end-of-interrupt pulse wrong");
  a_eoi_id: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    wr && addr_i == `OFS_EOI |=> eoi_id_o == $past(wdata_i[9:0]) && run_q == `RST_IDLE_PRI)
    else $error("end-of-interrupt id or running priority wrong");

  // Outputs are registered, so they answer the state of the cycle before
  a_irq_ns: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    pend_valid_i && !pend_secure_i && pend_prio_i < pmask_q[7:0] && pend_prio_i < run_q
    && ctrl_q[`CTRL_EN_NS] |=> !irq_n_o)
    else $error("enabled non-secure interrupt not signalled");
  a_fiq_route: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    pend_valid_i && pend_secure_i && pend_prio_i < pmask_q[7:0] && pend_prio_i < run_q
    && ctrl_q[`CTRL_EN_S] && ctrl_q[`CTRL_FIQ_SEL] |=> !fiq_n_o)
    else $error("secure interrupt not routed to the fast line");
  a_ns_blocked: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    pend_valid_i && !pend_secure_i && pend_prio_i < pmask_q[7:0] && pend_prio_i < run_q
    && !ctrl_q[`CTRL_EN_NS] |=> st_q == ST_NS_BLOCKED)
    else $error("blocked non-secure interrupt did not hold the interface");
  a_ns_quiet: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    st_q == ST_NS_BLOCKED && $past(lirq_s[1]) |-> irq_n_o)
    else $error("non-secure interrupt signalled while disabled");
  a_dos_quiet: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    st_q == ST_NS_BLOCKED && $past(lfiq_s[1]) |-> fiq_n_o)
    else $error("secure line raised while a blocked source outranks it");
  a_disabled: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ctrl_q[1:0] == 2'b00 && lirq_s[1] && lfiq_s[1] |=> irq_n_o && fiq_n_o)
    else $error("disabled interface signalled");
  a_legacy_fiq: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !ctrl_q[`CTRL_EN_S] && !lfiq_s[1] |=> !fiq_n_o)
    else $error("legacy fast input not passed while secure disabled");
  a_legacy_mask: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ctrl_q[`CTRL_EN_NS] && !pend_valid_i |=> irq_n_o)
    else $error("legacy input passed while non-secure enabled");
endmodule

/* File: test/cpu_core_model.sv */
// Processor core model: issues register accesses and returns read data and hit
`timescale 1ns/100ps
module cpu_core_model (
  input wire logic sys_clk_i,
  input wire cpu_if_pkg::word_t rdata_i,
  input wire logic ready_i,
  output logic sel_o,
  output logic write_o,
  output logic [11:0] addr_o,
  output logic [1:0] size_o,
  output logic [31:0] wdata_o,
  output logic secure_o,
  output logic [7:0] cpu_id_o
);
  import cpu_if_pkg::*;
  initial begin
    sel_o = 1'b0;
    write_o = 1'b0;
    addr_o = 12'h000;
    size_o = 2'h2;
    wdata_o = 32'h0000_0000;
    secure_o = 1'b0;
    cpu_id_o = 8'h02;
  end
  // One access; reads keep the request up three cycles because read data comes late
  task automatic access(input logic wr, input logic [11:0] a, input logic [1:0] sz, input logic [31:0] wd,
                        input logic sec, output word_t rd, output logic hit);
    int n;
    @(negedge sys_clk_i);
    sel_o = 1'b1;
    write_o = wr;
    addr_o = a;
    size_o = sz;
    wdata_o = wd;
    secure_o = sec;
    hit = 1'b0;
    for (n = 0; n < 4; n++) begin
      @(negedge sys_clk_i);
      if (ready_i === 1'b1) hit = 1'b1;
      if (wr || n == 2) sel_o = 1'b0;
    end
    rd = rdata_i;
    // Released lines show no stale value
    addr_o = ~a;
    wdata_o = ~wd;
  endtask
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the CPU interface register bank
`timescale 1ns/100ps
module tb_top;
  import cpu_if_pkg::*;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] match_i = 8'h00;
  logic [7:0] enable_i = 8'h00;
  logic pend_valid_i = 1'b0;
  int_id_t pend_id_i = 10'h000;
  prio_t pend_prio_i = 8'hFF;
  logic pend_secure_i = 1'b0;
  logic legacy_irq_n = 1'b1;
  logic legacy_fiq_n = 1'b1;
  logic sel, write, secure, ready, irq_n, fiq_n, eoi_valid;
  logic [11:0] addr;
  logic [1:0] size;
  logic [31:0] wdata;
  logic [7:0] cpu_id;
  logic [9:0] eoi_id;
  word_t rdata;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  int eoi_cnt = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  cpu_if_regbank #(.BPT_RESET(3'h2)) cpu_if_regbank_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sel_i(sel),
    .write_i(write), .addr_i(addr), .size_i(size), .wdata_i(wdata), .secure_i(secure), .match_i(match_i),
    .enable_i(enable_i), .cpu_id_i(cpu_id), .pend_valid_i(pend_valid_i), .pend_id_i(pend_id_i),
    .pend_prio_i(pend_prio_i), .pend_secure_i(pend_secure_i),
    .legacy_irq_n_i(legacy_irq_n), .legacy_fiq_n_i(legacy_fiq_n),
    .rdata_o(rdata), .ready_o(ready), .irq_n_o(irq_n), .fiq_n_o(fiq_n), .eoi_id_o(eoi_id),
    .eoi_valid_o(eoi_valid));

  cpu_core_model cpu_core_model_i (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .ready_i(ready), .sel_o(sel),
    .write_o(write), .addr_o(addr), .size_o(size), .wdata_o(wdata), .secure_o(secure), .cpu_id_o(cpu_id));

  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (eoi_valid === 1'b1) eoi_cnt <= eoi_cnt + 1;
    if (cycles == 3000) begin
      error_cnt = error_cnt + 1;
      close_out();
    end
  end

  task automatic chk(input word_t got, input word_t exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic sec, input word_t exp);
    word_t got;
    logic hit;
    cpu_core_model_i.access(1'b0, a, 2'h2, 32'h0000_0000, sec, got, hit);
    chk(got, exp);
  endtask

  task automatic wr(input logic [11:0] a, input logic [1:0] sz, input word_t d, input logic sec);
    word_t got;
    logic hit;
    cpu_core_model_i.access(1'b1, a, sz, d, sec, got, hit);
  endtask

  task automatic t_reset();
    chk({30'h0, irq_n, fiq_n}, 32'h0000_0003);
    rd(12'h000, 1'b1, 32'h0000_0000);
    rd(12'h004, 1'b1, 32'h0000_0000);
    rd(12'h008, 1'b1, 32'h0000_0002);
    rd(12'h00C, 1'b1, 32'h0000_03FF);
    rd(12'h014, 1'b1, 32'h0000_00FF);
    rd(12'h018, 1'b1, 32'h0000_03FF);
    rd(12'h01C, 1'b1, 32'h0000_0000);
  endtask

  // Legacy pins pass through while both enables are clear and are held off once both enables are set
  task automatic t_legacy();
    legacy_irq_n = 1'b0;
    legacy_fiq_n = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    chk({30'h0, irq_n, fiq_n}, 32'h0000_0000);
    wr(12'h000, 2'h2, 32'h0000_0003, 1'b1);
    repeat (4) @(negedge sys_clk_i);
    chk({30'h0, irq_n, fiq_n}, 32'h0000_0003);
    legacy_irq_n = 1'b1;
    legacy_fiq_n = 1'b1;
    wr(12'h000, 2'h2, 32'h0000_0000, 1'b1);
    repeat (4) @(negedge sys_clk_i);
  endtask

  task automatic t_regs();
    wr(12'h004, 2'h0, 32'h0000_0033, 1'b1);
    rd(12'h004, 1'b1, 32'h0000_0033);
    wr(12'h005, 2'h0, 32'h0000_7700, 1'b1);
    rd(12'h004, 1'b1, 32'h0000_0033);
    wr(12'h000, 2'h1, 32'h0000_000B, 1'b1);
    rd(12'h000, 1'b1, 32'h0000_000B);
    wr(12'h002, 2'h1, 32'h000F_0000, 1'b1);
    rd(12'h000, 1'b1, 32'h0000_000B);
    wr(12'h009, 2'h0, 32'h0000_0700, 1'b1);
    rd(12'h008, 1'b1, 32'h0000_0002);
    wr(12'h000, 2'h2, 32'h0000_0000, 1'b1);
    wr(12'h00C, 2'h2, 32'h0000_0055, 1'b1);
    rd(12'h00C, 1'b1, 32'h0000_03FF);
    wr(12'h014, 2'h2, 32'h0000_0012, 1'b1);
    rd(12'h014, 1'b1, 32'h0000_00FF);
    rd(12'h020, 1'b1, 32'h0000_0000);
    wr(12'h01C, 2'h2, 32'h0000_0001, 1'b0);
    rd(12'h01C, 1'b1, 32'h0000_0000);
    wr(12'h01C, 2'h2, 32'h0000_0001, 1'b1);
    rd(12'h01C, 1'b1, 32'h0000_0001);
    rd(12'h01C, 1'b0, 32'h0000_0000);
  endtask

  task automatic t_ident();
    word_t got;
    logic hit;
    rd(12'h0FC, 1'b0, {12'h123, 4'h2, 4'h3, 4'h5, 1'b0, 7'h2A});
    cpu_core_model_i.access(1'b0, 12'hFC0, 2'h0, 32'h0000_0000, 1'b0, got, hit);
    chk({31'h0, got[7]}, 32'h0000_0001);
  endtask

  task automatic t_select();
    word_t got;
    logic hit;
    match_i = 8'h01;
    enable_i = 8'h0F;
    cpu_core_model_i.access(1'b0, 12'h014, 2'h2, 32'h0000_0000, 1'b1, got, hit);
    chk({31'h0, hit}, 32'h0000_0000);
    match_i = 8'h02;
    cpu_core_model_i.access(1'b0, 12'h014, 2'h2, 32'h0000_0000, 1'b1, got, hit);
    chk({31'h0, hit}, 32'h0000_0001);
  endtask

  task automatic t_signal();
    int n;
    wr(12'h004, 2'h2, 32'h0000_00F0, 1'b1);
    pend_id_i = 10'h02A;
    pend_prio_i = 8'h40;
    pend_valid_i = 1'b1;
    wr(12'h000, 2'h2, 32'h0000_0001, 1'b1);
    repeat (8) @(negedge sys_clk_i);
    chk({31'h0, irq_n}, 32'h0000_0001);
    wr(12'h000, 2'h2, 32'h0000_0003, 1'b1);
    for (n = 0; n < 8 && irq_n !== 1'b0; n++) @(negedge sys_clk_i);
    chk({31'h0, irq_n}, 32'h0000_0000);
    rd(12'h018, 1'b1, 32'h0000_002A);
    rd(12'h00C, 1'b1, 32'h0000_002A);
    pend_valid_i = 1'b0;
    rd(12'h014, 1'b1, 32'h0000_0040);
    wr(12'h010, 2'h2, 32'h0000_002A, 1'b1);
    chk(eoi_cnt, 32'h0000_0001);
    chk({22'h0, eoi_id}, 32'h0000_002A);
    rd(12'h014, 1'b1, 32'h0000_00FF);
    // Secure source at 8'h10 sits above the earlier non-secure one at 8'h40
    pend_prio_i = 8'h10;
    pend_id_i = 10'h011;
    pend_secure_i = 1'b1;
    pend_valid_i = 1'b1;
    wr(12'h000, 2'h2, 32'h0000_000B, 1'b1);
    for (n = 0; n < 8 && fiq_n !== 1'b0; n++) @(negedge sys_clk_i);
    chk({31'h0, fiq_n}, 32'h0000_0000);
    rd(12'h00C, 1'b1, 32'h0000_0011);
    // Non-secure signalling off, then a non-secure source above the running secure one
    wr(12'h000, 2'h2, 32'h0000_0009, 1'b1);
    pend_id_i = 10'h033;
    pend_prio_i = 8'h08;
    pend_secure_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk({30'h0, irq_n, fiq_n}, 32'h0000_0003);
    rd(12'h018, 1'b1, 32'h0000_0033);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    resetn_i = 1'b1;
    t_reset();
    t_legacy();
    t_regs();
    t_ident();
    t_select();
    t_signal();
    close_out();
  end
endmodule
